// file: rtl/dea_pkg.sv
// Constants shared by the data NVM access controller.
// Assumes a byte-wide CPU I/O register port; the byte array sits inside dea_ctrl.
// Operation
// - One linear byte space of 128, 256 or 512 bytes; each access is one byte.
// - Address, data and control registers sit in the CPU I/O register space.
// - Starting a read stalls the CPU for four clock cycles.
// - Starting programming stalls the CPU for two clock cycles.
// - Mode 00 plus enable inside the master window starts erase and write.
// - Mode 01 with the enable sequence erases the addressed byte only.
// - Mode 10 with the enable sequence writes data without erasing first.
// - Program enable reads one until the operation has fully completed.
// - While programming, any other read or programming start is refused.
// - Programming time comes from the calibrated oscillator, not CPU clock.
// - Read loads the addressed byte into the data register at once.
// - Address is nine bits; top bit reads zero on smaller variants.
package dea_pkg;
   // I/O addresses of the access registers
   localparam logic [5:0] ADDR_ADDR_HI = 6'h1F;
   localparam logic [5:0] ADDR_ADDR_LO = 6'h1E;
   localparam logic [5:0] ADDR_DATA    = 6'h1D;
   localparam logic [5:0] ADDR_CTRL    = 6'h1C;
   // Control register field positions
   localparam int BIT_READ_EN   = 0;
   localparam int BIT_PROG_EN   = 1;
   localparam int BIT_MASTER_EN = 2;
   localparam int BIT_INT_EN    = 3;
   localparam int BIT_MODE_LO   = 4;
   localparam int BIT_MODE_HI   = 5;
   // Programming modes
   localparam logic [1:0] MODE_ATOMIC = 2'h0;
   localparam logic [1:0] MODE_ERASE  = 2'h1;
   localparam logic [1:0] MODE_WRITE  = 2'h2;
   // Reset values and erased content
   localparam logic [7:0] DATA_RESET  = 8'h00;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   // Timing counts in CPU cycles
   localparam logic [2:0] READ_STALL   = 3'h4;
   localparam logic [2:0] PROG_STALL   = 3'h2;
   localparam logic [2:0] MASTER_WIN   = 3'h4;
   // Programming time in oscillator ticks
   localparam logic [15:0] PROG_TICKS  = 16'h0100;
   // Array sizes: 0 = 128, 1 = 256, 2 = 512 bytes
   localparam logic [1:0] SIZE_128 = 2'h0;
   localparam logic [1:0] SIZE_256 = 2'h1;
   localparam logic [1:0] SIZE_512 = 2'h2;
   localparam int ARRAY_DEPTH = 512;

   typedef enum logic [1:0] {
      DEA_IDLE,
      DEA_ERASE,
      DEA_WRITE
   } dea_state_type;
endpackage : dea_pkg

// file: rtl/dea_osc_timer.sv
// Programming duration timer counting oscillator ticks.
// Assumes i_osc_level is an asynchronous toggle from the calibrated oscillator.
`timescale 1ns/1ps
`default_nettype none
module dea_osc_timer
   import dea_pkg::*;
(
   // Clock and reset
   input  wire logic i_clock,
   input  wire logic i_rst_b,
   // Control
   input  wire logic i_start,
   input  wire logic i_osc_level,
   // Status
   output logic      o_done
);
   logic [2:0]  sync;
   logic        prev;
   logic [15:0] count;
   logic        running;
   logic        tick;

   // Change counts once the second and third stage agree
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         sync <= 3'h0;
         prev <= 1'b0;
      end else begin
         sync <= {sync[1:0], i_osc_level};
         if (sync[2] == sync[1]) begin
            prev <= sync[2];
         end
      end
   end

   // Oscillator edge, not CPU cycles, paces programming
   assign tick = (sync[2] == sync[1]) && (sync[2] != prev);

   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         count   <= 16'h0000;
         running <= 1'b0;
         o_done  <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (i_start) begin
            count   <= PROG_TICKS;
            running <= 1'b1;
         end else if (running && tick) begin
            if (count == 16'h0001) begin
               running <= 1'b0;
               o_done  <= 1'b1;
            end
            count <= count - 16'h0001;
         end
      end
   end
endmodule : dea_osc_timer
`default_nettype wire

// file: rtl/dea_ctrl.sv
// Data NVM access controller: I/O registers, timed enable, stall, array.
// Assumes one I/O access per cycle from the CPU; strobes are single cycle.
`timescale 1ns/1ps
`default_nettype none
module dea_ctrl
   import dea_pkg::*;
(
   // Clock and reset
   input  wire logic       i_clock,
   input  wire logic       i_rst_b,
   // Variant size select
   input  wire logic [1:0] i_size_sel,
   // CPU I/O register port
   input  wire logic [5:0] i_io_addr,
   input  wire logic       i_io_wr,
   input  wire logic       i_io_rd,
   input  wire logic [7:0] i_io_wdata,
   output logic [7:0]      o_io_rdata,
   // CPU stall
   output logic            o_cpu_stall,
   // Calibrated oscillator level
   input  wire logic       i_osc_level,
   // Status
   output logic            o_busy
);
   logic [7:0]    mem [0:ARRAY_DEPTH-1];
   logic [7:0]    nvm_addr_low;
   logic          nvm_addr_top_bit;
   logic [7:0]    nvm_data_reg;
   logic [1:0]    prog_mode_field;
   logic          int_en;
   logic          prog_enable_bit;
   logic          master_prog_enable_bit;
   logic [2:0]    master_count;
   logic [2:0]    stall_count;
   dea_state_type state;
   logic          timer_start;
   logic          timer_done;
   logic          wr_ctrl;
   logic          start_read;
   logic          start_prog;
   logic [8:0]    eff_addr;

   // Mask address to the size of the fitted array
   function automatic logic [8:0] mask_addr(input logic [1:0] sz,
                                            input logic       top,
                                            input logic [7:0] low);
      logic [8:0] a;
      a = {top, low};
      unique case (sz)
         SIZE_128: a = {2'h0, low[6:0]};
         SIZE_256: a = {1'b0, low};
         default:  a = {top, low};
      endcase
      return a;
   endfunction : mask_addr

   assign eff_addr = mask_addr(i_size_sel, nvm_addr_top_bit,
                               nvm_addr_low);
   assign wr_ctrl  = i_io_wr && (i_io_addr == ADDR_CTRL);
   assign start_read = wr_ctrl && i_io_wdata[BIT_READ_EN]
                       && !prog_enable_bit;
   // Program enable only acts inside the master window
   assign start_prog = wr_ctrl && i_io_wdata[BIT_PROG_EN]
                       && master_prog_enable_bit
                       && !prog_enable_bit;
   assign timer_start = start_prog;
   assign o_cpu_stall = (stall_count != 3'h0);
   assign o_busy      = prog_enable_bit;

   // Address and mode registers; held while programming so target is stable
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         nvm_addr_low     <= 8'h00;
         nvm_addr_top_bit <= 1'b0;
         prog_mode_field  <= MODE_ATOMIC;
         int_en           <= 1'b0;
      end else if (i_io_wr && !prog_enable_bit) begin
         if (i_io_addr == ADDR_ADDR_LO) begin
            nvm_addr_low <= i_io_wdata;
         end
         if (i_io_addr == ADDR_ADDR_HI) begin
            nvm_addr_top_bit <= i_io_wdata[0];
         end
         if (i_io_addr == ADDR_CTRL) begin
            prog_mode_field <= i_io_wdata[BIT_MODE_HI:BIT_MODE_LO];
            int_en          <= i_io_wdata[BIT_INT_EN];
         end
      end
   end

   // Master enable window: self clears after four cycles
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         master_prog_enable_bit <= 1'b0;
         master_count           <= 3'h0;
      end else if (wr_ctrl && i_io_wdata[BIT_MASTER_EN]
                   && !i_io_wdata[BIT_PROG_EN]) begin
         master_prog_enable_bit <= 1'b1;
         master_count           <= MASTER_WIN;
      end else if (start_prog) begin
         master_prog_enable_bit <= 1'b0;
         master_count           <= 3'h0;
      end else if (master_count != 3'h0) begin
         master_count <= master_count - 3'h1;
         if (master_count == 3'h1) begin
            master_prog_enable_bit <= 1'b0;
         end
      end
   end

   // Busy flag stands from start until the timed operation completes
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         prog_enable_bit <= 1'b0;
         state           <= DEA_IDLE;
      end else begin
         unique case (state)
            DEA_IDLE: begin
               if (start_prog) begin
                  prog_enable_bit <= 1'b1;
                  state <= (prog_mode_field == MODE_WRITE) ? DEA_WRITE
                                                           : DEA_ERASE;
               end
            end
            DEA_ERASE, DEA_WRITE: begin
               if (timer_done) begin
                  prog_enable_bit <= 1'b0;
                  state           <= DEA_IDLE;
               end
            end
         endcase
      end
   end

   // Stall counter: four cycles for a read, two for programming
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         stall_count <= 3'h0;
      end else if (start_read) begin
         stall_count <= READ_STALL;
      end else if (start_prog) begin
         stall_count <= PROG_STALL;
      end else if (stall_count != 3'h0) begin
         stall_count <= stall_count - 3'h1;
      end
   end

   // Data register: software writes, reads return array contents
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         nvm_data_reg <= DATA_RESET;
      end else if (start_read) begin
         nvm_data_reg <= mem[eff_addr];
      end else if (i_io_wr && (i_io_addr == ADDR_DATA)
                   && !prog_enable_bit) begin
         nvm_data_reg <= i_io_wdata;
      end
   end

   // Array update at the end of the timed operation
   always_ff @(posedge i_clock) begin
      if (timer_done && state != DEA_IDLE) begin
         unique case (prog_mode_field)
            MODE_ATOMIC: mem[eff_addr] <= nvm_data_reg;
            MODE_ERASE:  mem[eff_addr] <= ERASED_BYTE;
            // Bits can only be cleared without a prior erase
            MODE_WRITE:  mem[eff_addr] <= mem[eff_addr]
                                          & nvm_data_reg;
            default:     mem[eff_addr] <= mem[eff_addr];
         endcase
      end
   end

   // Read-back mux; reserved bits read zero
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         o_io_rdata <= 8'h00;
      end else if (i_io_rd) begin
         unique case (i_io_addr)
            ADDR_ADDR_HI: o_io_rdata <= {7'h00,
                                         eff_addr[8]};
            ADDR_ADDR_LO: o_io_rdata <= eff_addr[7:0];
            ADDR_DATA:    o_io_rdata <= nvm_data_reg;
            ADDR_CTRL:    o_io_rdata <= {2'h0, prog_mode_field, int_en,
                                         master_prog_enable_bit,
                                         prog_enable_bit, 1'b0};
            default:      o_io_rdata <= 8'h00;
         endcase
      end
   end

   dea_osc_timer u_timer (
      .i_clock     (i_clock),
      .i_rst_b     (i_rst_b),
      .i_start     (timer_start),
      .i_osc_level (i_osc_level),
      .o_done      (timer_done)
   );
endmodule : dea_ctrl
`default_nettype wire

// file: verif/dea_osc_model.sv
// Calibrated oscillator stand-in for the programming timer.
// Assumes nothing of the CPU clock; toggles only while enabled.
`timescale 1ns/1ps
`default_nettype none
module dea_osc_model (
   // Control
   input  wire logic i_run,
   // Oscillator level
   output logic      o_level
);
   initial o_level = 1'b0;
   // Odd half period keeps it unrelated to the 10 ns clock
   // Each level spans three clocks or more, so no change is filtered out
   always #37 if (i_run) o_level = ~o_level;
endmodule : dea_osc_model
`default_nettype wire

// file: verif/dea_ctrl_assertions.sv
// Port timing checks for the NVM access controller.
// Bound to dea_ctrl; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module dea_ctrl_assertions
   import dea_pkg::*;
(
   input  wire logic       i_clock,
   input  wire logic       i_rst_b,
   input  wire logic [1:0] i_size_sel,
   input  wire logic [5:0] i_io_addr,
   input  wire logic       i_io_wr,
   input  wire logic       i_io_rd,
   input  wire logic [7:0] i_io_wdata,
   input  wire logic [7:0] o_io_rdata,
   input  wire logic       o_cpu_stall,
   input  wire logic       i_osc_level,
   input  wire logic       o_busy
);
   logic [2:0] win;
   wire ctl_wr = i_io_wr && i_io_addr == ADDR_CTRL;
   wire m_wr = ctl_wr && i_io_wdata[2:1] == 2'h2 && !o_busy;
   wire e_wr = ctl_wr && i_io_wdata[1] && !o_busy;
   // Window mirrored from port traffic, not from internal state
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) win <= 3'h0;
      else if (m_wr) win <= MASTER_WIN;
      else if (win != 3'h0) win <= win - 3'h1;
   end
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);
   sequence s_rd_stall; o_cpu_stall [*4] ##1 !o_cpu_stall; endsequence
   sequence s_pg_stall; o_cpu_stall [*2] ##1 !o_cpu_stall; endsequence
   property p_rd_stall;
      ctl_wr && i_io_wdata[2:0] == 3'h1 && !o_busy && !o_cpu_stall
         |=> s_rd_stall;
   endproperty
   a_rd_stall: assert property (p_rd_stall) else $error("read stall");
   property p_prog; e_wr && win != 3'h0 |=> o_busy ##0 s_pg_stall; endproperty
   a_prog: assert property (p_prog) else $error("prog start");
   property p_no_master; e_wr && win == 3'h0 |=> !o_busy; endproperty
   a_no_master: assert property (p_no_master) else $error("late");
   property p_busy_hold; $rose(o_busy) |-> o_busy [*8]; endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("busy");
   property p_refuse;
      o_busy && !o_cpu_stall && ctl_wr && i_io_wdata[0] |=> !o_cpu_stall;
   endproperty
   a_refuse: assert property (p_refuse) else $error("refuse");
   property p_top_zero;
      i_io_rd && i_io_addr == ADDR_ADDR_HI && i_size_sel != SIZE_512
         |=> o_io_rdata == 8'h00;
   endproperty
   a_top_zero: assert property (p_top_zero) else $error("top bit");
   property p_ctrl_rd;
      i_io_rd && i_io_addr == ADDR_CTRL
         |=> o_io_rdata[1:0] == {$past(o_busy), 1'b0};
   endproperty
   a_ctrl_rd: assert property (p_ctrl_rd) else $error("ctrl read");
   property p_stall_src; $rose(o_cpu_stall) |-> $past(ctl_wr); endproperty
   a_stall_src: assert property (p_stall_src) else $error("stall");
endmodule : dea_ctrl_assertions
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for dea_ctrl with a byte-array model.
// Assumes the oscillator model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import dea_pkg::*;
   logic       i_clock = 1'b0, i_rst_b = 1'b0, i_io_wr = 1'b0;
   logic       i_io_rd = 1'b0, osc_run = 1'b1;
   logic [1:0] i_size_sel = SIZE_512;
   logic [5:0] i_io_addr = 6'h00;
   logic [7:0] i_io_wdata = 8'h00, v, o_io_rdata;
   logic       o_cpu_stall, o_busy, i_osc_level;
   int         bad_count = 0, n_compared = 0;
   logic [31:0] rs = 32'h3B, r;
   logic [7:0] mem [512];
   logic [8:0] a;
   dea_osc_model i_osc (.i_run(osc_run), .o_level(i_osc_level));
   dea_ctrl i_dut (.i_clock(i_clock), .i_rst_b(i_rst_b),
      .i_size_sel(i_size_sel), .i_io_addr(i_io_addr), .i_io_wr(i_io_wr),
      .i_io_rd(i_io_rd), .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata),
      .o_cpu_stall(o_cpu_stall), .i_osc_level(i_osc_level), .o_busy(o_busy));
   initial forever #5 i_clock = ~i_clock;
   function automatic logic [31:0] xs();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction : xs
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic end_of_test();
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test
   task automatic wr(input logic [5:0] ad, input logic [7:0] d);
      @(posedge i_clock);
      #1 {i_io_addr, i_io_wdata, i_io_wr} = {ad, d, 1'b1};
      @(posedge i_clock);
      #1 i_io_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [5:0] ad);
      @(posedge i_clock);
      #1 {i_io_addr, i_io_rd} = {ad, 1'b1};
      @(posedge i_clock);
      #1 i_io_rd = 1'b0;
      v = o_io_rdata;
   endtask : rd
   task automatic seta(input logic [8:0] ad);
      wr(ADDR_ADDR_HI, {7'h00, ad[8]});
      wr(ADDR_ADDR_LO, ad[7:0]);
   endtask : seta
   task automatic nvm_rd(input logic [8:0] ad);
      seta(ad);
      wr(ADDR_CTRL, 8'h01);
      for (int i = 0; i < 8 && o_cpu_stall !== 1'b0; i++) @(posedge i_clock);
      rd(ADDR_DATA);
   endtask : nvm_rd
   // Software side: address, data, mode, master, enable, then poll busy
   task automatic prog(input logic [1:0] m, input logic [8:0] ad,
                       input logic [7:0] d);
      seta(ad);
      wr(ADDR_DATA, d);
      wr(ADDR_CTRL, {2'h0, m, 4'h0});
      wr(ADDR_CTRL, {2'h0, m, 4'h4});
      wr(ADDR_CTRL, {2'h0, m, 4'h2});
      osc_run = 1'b0;
      repeat (30) @(posedge i_clock);
      #1 check({7'h00, o_busy}, 8'h01);
      wr(ADDR_CTRL, {2'h0, m, 4'h1});
      rd(ADDR_DATA);
      check(v, d);
      rd(ADDR_CTRL);
      check({6'h00, v[1:0]}, 8'h02);
      osc_run = 1'b1;
      for (int i = 0; i < 2000 && o_busy !== 1'b0; i++) @(posedge i_clock);
      case (m)
         MODE_ATOMIC: mem[ad] = d;
         MODE_ERASE: mem[ad] = ERASED_BYTE;
         default: mem[ad] = mem[ad] & d;
      endcase
      nvm_rd(ad);
      check(v, mem[ad]);
   endtask : prog
   initial begin
      #200000 bad_count++;
      end_of_test();
   end
   initial begin
      repeat (5) @(posedge i_clock);
      #1 i_rst_b = 1'b1;
      rd(ADDR_DATA);
      check(v, DATA_RESET);
      rd(ADDR_CTRL);
      check({4'h0, v[3:0]}, 8'h00);
      $display("reset test done");
      for (int s = 0; s < 3; s++) begin
         i_size_sel = s[1:0];
         seta(9'h1FF);
         a = (s == 0) ? 9'h07F : (s == 1) ? 9'h0FF : 9'h1FF;
         rd(ADDR_ADDR_HI);
         check(v, {7'h00, a[8]});
         rd(ADDR_ADDR_LO);
         check(v, a[7:0]);
      end
      $display("size test done");
      for (int k = 0; k < 9; k++) begin
         r = xs();
         if (k % 3 == 0) a = r[16:8];
         prog(2'(k % 3), a, r[7:0]);
      end
      $display("mode test done");
      wr(ADDR_DATA, ~mem[a]);
      wr(ADDR_CTRL, 8'h04);
      repeat (4) @(posedge i_clock);
      wr(ADDR_CTRL, 8'h02);
      check({7'h00, o_busy}, 8'h00);
      nvm_rd(a);
      check(v, mem[a]);
      $display("window test done");
      end_of_test();
   end
endmodule : testbench
bind dea_ctrl dea_ctrl_assertions i_chk (.i_clock(i_clock),
   .i_rst_b(i_rst_b), .i_size_sel(i_size_sel), .i_io_addr(i_io_addr),
   .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .i_io_wdata(i_io_wdata),
   .o_io_rdata(o_io_rdata), .o_cpu_stall(o_cpu_stall),
   .i_osc_level(i_osc_level), .o_busy(o_busy));
`default_nettype wire
